// [mcu_bus_host_port.sv]
// Device end: latches the bus address, decodes memories and drives read data.
//
// Contract
// - Latch both ports on address strobe.
// - Drive data only when read and selected.
// - Forward latched address to programmable logic.
// - Multiplexed host: low byte lower port.
// - Plain host: low address on lower port.
// - Burst host: lines shifted four bits.
// - Write control accepts active-low strobe.
// - Write control accepts read/write direction.
// - Read control accepts four strobe styles.
// - Controls also routed to programmable logic.
// - Program select input, or generic input.
// - Reset clears ports, macrocells, some configuration.
// - Host holds reset low at power-up.
// - Fetch one array while other programs.
// - Map memories segment by segment.
// - Secondary memory removable after programming.
// - Arrays reclassifiable as data space.
// - Page register extends address range.
// - Serial port programs blank device.
`timescale 1ns/1ps
`default_nettype none
module mcu_bus_host_port
    import mcu_bus_pkg::*;
(
    // Clock and reset.
    input  wire logic                       clk,
    input  wire logic                       rst,
    // Static configuration.
    input  wire bus_mode_type               bus_mode,
    input  wire write_style_type            write_style,
    input  wire read_style_type             read_style,
    input  wire logic                       program_store_enable_n_used,
    // Memory map setup and programming controls.
    input  wire logic [SEGMENT_COUNT-1:0]   primary_seg_map,
    input  wire logic [SEGMENT_COUNT-1:0]   secondary_seg_map,
    input  wire logic                       secondary_swap_out,
    input  wire logic                       primary_as_data,
    input  wire logic                       secondary_as_data,
    input  wire logic                       serial_prog_active,
    // Pins.
    mcu_bus_if.device                       bus,
    // Toward programmable logic and memories.
    output logic [ADDR_WIDTH-1:0]           pld_addr,
    output logic [MEM_ADDR_WIDTH-1:0]       mem_addr,
    output logic                            pld_write,
    output logic                            pld_read,
    output logic                            pld_generic_in,
    output logic                            write_strobe,
    output logic [15:0]                     write_data,
    output select_type                      selected,
    output logic                            primary_busy_ok,
    output logic [PAGE_WIDTH-1:0]           page,
    // Read data and busy flags from memories.
    input  wire logic [15:0]                primary_rdata,
    input  wire logic [15:0]                secondary_rdata,
    input  wire logic                       primary_busy,
    input  wire logic                       secondary_busy
);

    // Synchroniser chains, one per pin input.
    localparam int NSYNC = 5;

    typedef struct packed
    {
        logic [NSYNC-1:0][SYNC_STAGES-1:0] sync;
        logic [NSYNC-1:0]                  level;
        logic [ADDR_WIDTH-1:0]             addr;
        logic [PAGE_WIDTH-1:0]             page;
        logic                              wr_seen;
        logic [15:0]                       rdata;
        logic                              drive;
        logic [15:0]                       wdata;
        logic                              wstrobe;
    } port_state_type;

    port_state_type          cur;
    port_state_type          next_cur;
    logic [NSYNC-1:0]        raw;
    logic                    strobe_rise;
    logic                    rd_active;
    logic                    wr_active;
    logic                    seg_hit_p;
    logic                    seg_hit_s;
    logic [15:0]             bus_word;
    logic [2:0]              seg;
    logic                    reset_in;

    ////////////////////////////////////////////////////////////////////////////
    // Pin inputs: strobe, write, read, program select, reset.
    assign raw = {bus.reset_n, bus.program_select_input, bus.read_control_input,
                  bus.write_control_input, bus.addr_strobe};
    assign bus_word = {bus.upper_addr_data_port, bus.lower_addr_data_port};

    // Decode of control styles and memory segments.
    always_comb
    begin
        strobe_rise = (cur.sync[0][2] == cur.sync[0][1]) && cur.sync[0][2] && !cur.level[0];
        wr_active   = (write_style == WR_STROBE) ? !cur.level[1] : !cur.level[1];
        case (read_style)
            RD_STROBE: rd_active = !cur.level[2];
            RD_ECLOCK: rd_active = cur.level[2] && cur.level[1];
            RD_DSTROB: rd_active = !cur.level[2] && cur.level[1];
            RD_PROGRAM_STORE_ENABLE_N:   rd_active = !cur.level[2];
            default:   rd_active = 1'b0;
        endcase
        if (write_style == WR_RW)
            wr_active = !cur.level[1] && !cur.level[2];
        if (program_store_enable_n_used && !cur.level[3])
            rd_active = 1'b1;
        seg       = cur.addr[ADDR_WIDTH-1:SEGMENT_SHIFT];
        seg_hit_p = primary_seg_map[seg] && !(primary_as_data && !cur.level[3] && program_store_enable_n_used);
        seg_hit_s = secondary_seg_map[seg] && !secondary_swap_out
                  && !(secondary_as_data && !cur.level[3] && program_store_enable_n_used);
        if (serial_prog_active)
            selected = SEL_NONE;
        else if (seg_hit_p && !primary_busy)
            selected = SEL_PRIMARY;
        else if (seg_hit_s && !secondary_busy)
            selected = SEL_SECONDARY;
        else if (cur.addr == {ADDR_WIDTH{1'b1}})
            selected = SEL_PAGE;
        else
            selected = SEL_NONE;
        reset_in = rst || !cur.level[4];
    end

    // Next state: synchronise, latch address, capture data.
    always_comb
    begin
        next_cur         = cur;
        next_cur.wstrobe = 1'b0;
        for (int i = 0; i < NSYNC; i++)
        begin
            next_cur.sync[i] = {cur.sync[i][1:0], raw[i]};
            if (cur.sync[i][2] == cur.sync[i][1])
                next_cur.level[i] = cur.sync[i][2];
        end
        // Capture the address as the strobe goes active; stage 3 agrees with 2.
        if (strobe_rise)
        begin
            next_cur.addr = (bus_mode == BUS_BURST)
                          ? 16'(bus_word << BURST_SHIFT) : bus_word;
        end
        // Write edge: take data once; page register write at top address.
        if (wr_active && !cur.wr_seen)
        begin
            next_cur.wstrobe = (selected != SEL_NONE);
            next_cur.wdata   = bus_word;
            if (selected == SEL_PAGE)
                next_cur.page = bus_word[PAGE_WIDTH-1:0];
        end
        next_cur.wr_seen = wr_active;
        next_cur.drive   = rd_active && (selected != SEL_NONE);
        case (selected)
            SEL_PRIMARY:   next_cur.rdata = primary_rdata;
            SEL_SECONDARY: next_cur.rdata = secondary_rdata;
            SEL_PAGE:      next_cur.rdata = {8'h00, cur.page};
            default:       next_cur.rdata = 16'h0000;
        endcase
        if (!cur.level[4])
        begin
            next_cur.page  = PAGE_RESET;
            next_cur.drive = 1'b0;
        end
    end

    // State register; sync chains start at the idle pin levels so no false edge follows reset.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cur <= '{sync: 15'h7ff8, level: 5'h1e, addr: ADDR_RESET, page: PAGE_RESET,
                     wr_seen: 1'b0, rdata: 16'h0000, drive: 1'b0, wdata: 16'h0000,
                     wstrobe: 1'b0};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs to pins and logic.
    always_comb
    begin
        bus.lower_dev_out = cur.rdata[7:0];
        bus.upper_dev_out = cur.rdata[15:8];
        bus.lower_dev_oe  = cur.drive && !reset_in;
        bus.upper_dev_oe  = cur.drive && !reset_in;
        pld_addr          = cur.addr;
        mem_addr          = {cur.page, cur.addr};
        pld_write         = cur.level[1];
        pld_read          = cur.level[2];
        pld_generic_in    = cur.level[3];
        write_strobe      = cur.wstrobe;
        write_data        = cur.wdata;
        page              = cur.page;
        primary_busy_ok   = !(primary_busy && secondary_busy);
    end

endmodule : mcu_bus_host_port
`default_nettype wire

// [mcu_bus_pkg.sv]
// Shared constants and types for the microcontroller bus port and its host end.
package mcu_bus_pkg;

    localparam int ADDR_WIDTH      = 16;
    localparam int BYTE_WIDTH      = 8;
    localparam int PAGE_WIDTH      = 8;
    localparam int MEM_ADDR_WIDTH  = ADDR_WIDTH + PAGE_WIDTH;
    localparam int SEGMENT_COUNT   = 8;
    localparam int SEGMENT_SHIFT   = 13;
    localparam int BURST_SHIFT     = 4;
    localparam int SYNC_STAGES     = 3;
    // Host phase lengths, minus one; each phase outlasts the device's pin filter.
    localparam int HOST_LATCH      = SYNC_STAGES;
    localparam int HOST_HOLD       = SYNC_STAGES + 2;

    // Reset values.
    localparam logic [7:0]  PAGE_RESET      = 8'h00;
    localparam logic [15:0] ADDR_RESET      = 16'h0000;
    localparam logic [7:0]  SEG_MAP_RESET   = 8'h0f;
    localparam logic [7:0]  DATA_SPACE_RST  = 8'h00;

    // Bus wiring modes of the host.
    typedef enum logic [1:0]
    {
        BUS_MUX   = 2'b00,
        BUS_PLAIN = 2'b01,
        BUS_BURST = 2'b10
    } bus_mode_type;

    // Write control styles.
    typedef enum logic
    {
        WR_STROBE = 1'b0,
        WR_RW     = 1'b1
    } write_style_type;

    // Read control styles.
    typedef enum logic [1:0]
    {
        RD_STROBE = 2'b00,
        RD_ECLOCK = 2'b01,
        RD_DSTROB = 2'b10,
        RD_PROGRAM_STORE_ENABLE_N   = 2'b11
    } read_style_type;

    // Memory targets from decode.
    typedef enum logic [1:0]
    {
        SEL_NONE      = 2'b00,
        SEL_PRIMARY   = 2'b01,
        SEL_SECONDARY = 2'b10,
        SEL_PAGE      = 2'b11
    } select_type;

endpackage : mcu_bus_pkg

// [mcu_bus_if.sv]
// Pin bundle between the host microcontroller and the bus port.
`timescale 1ns/1ps
`default_nettype none
interface mcu_bus_if;
    // Lower and upper address/data ports, split into drive signals.
    logic [7:0] lower_host_out;
    logic       lower_host_oe;
    logic [7:0] upper_host_out;
    logic       upper_host_oe;
    logic [7:0] lower_dev_out;
    logic       lower_dev_oe;
    logic [7:0] upper_dev_out;
    logic       upper_dev_oe;
    logic [7:0] lower_addr_data_port;
    logic [7:0] upper_addr_data_port;
    // Control pins.
    logic       addr_strobe;
    logic       write_control_input;
    logic       read_control_input;
    logic       program_select_input;
    logic       reset_n;

    // Resolved bus level; undriven lines read low here.
    assign lower_addr_data_port = lower_host_oe ? lower_host_out
                                : (lower_dev_oe ? lower_dev_out : 8'h00);
    assign upper_addr_data_port = upper_host_oe ? upper_host_out
                                : (upper_dev_oe ? upper_dev_out : 8'h00);

    modport device
    (
        input  lower_addr_data_port, upper_addr_data_port, addr_strobe,
        input  write_control_input, read_control_input, program_select_input, reset_n,
        output lower_dev_out, lower_dev_oe, upper_dev_out, upper_dev_oe
    );
    modport host
    (
        input  lower_addr_data_port, upper_addr_data_port,
        output lower_host_out, lower_host_oe, upper_host_out, upper_host_oe,
        output addr_strobe, write_control_input, read_control_input,
        output program_select_input, reset_n
    );
endinterface : mcu_bus_if
`default_nettype wire

// [mcu_bus_host.sv]
// Host end: drives multiplexed, plain or burst bus cycles onto the port pins.
`timescale 1ns/1ps
`default_nettype none
module mcu_bus_host
    import mcu_bus_pkg::*;
(
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst,
    // Wiring style of this host.
    input  wire bus_mode_type     bus_mode,
    input  wire write_style_type  write_style,
    // Request side.
    input  wire logic             req_valid,
    output logic                  req_ready,
    input  wire logic             req_write,
    input  wire logic             req_code,
    input  wire logic [15:0]      req_addr,
    input  wire logic [15:0]      req_wdata,
    // Answer side.
    output logic                  rsp_valid,
    output logic [15:0]           rsp_rdata,
    // Pins.
    mcu_bus_if.host               bus
);

    typedef enum logic [2:0]
    {
        H_IDLE  = 3'b000,
        H_ADDR  = 3'b001,
        H_LATCH = 3'b010,
        H_DATA  = 3'b011,
        H_DONE  = 3'b100
    } hstate_type;

    typedef struct packed
    {
        hstate_type  st;
        logic [2:0]  cnt;
        logic        wr;
        logic        code;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic        rvalid;
        logic        rst_n;
    } host_state_type;

    host_state_type cur;
    host_state_type next_cur;
    logic [7:0]     lo_addr;
    logic [7:0]     hi_addr;
    logic [15:0]    burst_addr;

    ////////////////////////////////////////////////////////////////////////////
    // Address placement per wiring style; burst shifts by four bits.
    always_comb
    begin
        burst_addr = cur.addr >> BURST_SHIFT;
        lo_addr    = (bus_mode == BUS_BURST) ? burst_addr[7:0] : cur.addr[7:0];
        hi_addr    = (bus_mode == BUS_BURST) ? burst_addr[15:8] : cur.addr[15:8];
    end

    // Sequencer: address, latch strobe, data phase, release.
    always_comb
    begin
        next_cur        = cur;
        next_cur.rvalid = 1'b0;
        next_cur.rst_n  = 1'b1;
        case (cur.st)
            H_IDLE:
            begin
                if (req_valid)
                begin
                    next_cur.st    = H_ADDR;
                    next_cur.wr    = req_write;
                    next_cur.code  = req_code;
                    next_cur.addr  = req_addr;
                    next_cur.wdata = req_wdata;
                end
            end
            H_ADDR:
            begin
                next_cur.st  = H_LATCH;
                next_cur.cnt = 3'(HOST_LATCH);
            end
            // The strobe stands long enough to pass the device's three-flop filter.
            H_LATCH:
            begin
                if (cur.cnt == 3'h0)
                begin
                    next_cur.st  = H_DATA;
                    next_cur.cnt = 3'(HOST_HOLD);
                end
                else
                begin
                    next_cur.cnt = cur.cnt - 3'h1;
                end
            end
            H_DATA:
            begin
                if (cur.cnt == 3'h0)
                begin
                    next_cur.st    = H_DONE;
                    next_cur.rdata = {bus.upper_addr_data_port, bus.lower_addr_data_port};
                end
                else
                begin
                    next_cur.cnt = cur.cnt - 3'h1;
                end
            end
            H_DONE:
            begin
                next_cur.st     = H_IDLE;
                next_cur.rvalid = ~cur.wr;
            end
            default: next_cur.st = H_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cur <= '{st: H_IDLE, cnt: 3'h0, wr: 1'b0, code: 1'b0, addr: ADDR_RESET,
                     wdata: 16'h0000, rdata: 16'h0000, rvalid: 1'b0, rst_n: 1'b0};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive.
    always_comb
    begin
        req_ready    = (cur.st == H_IDLE);
        rsp_valid    = cur.rvalid;
        rsp_rdata    = cur.rdata;
        bus.reset_n  = cur.rst_n;
        bus.addr_strobe = (cur.st == H_LATCH);
        bus.lower_host_out = (cur.st == H_DATA && cur.wr) ? cur.wdata[7:0] : lo_addr;
        bus.upper_host_out = (cur.st == H_DATA && cur.wr) ? cur.wdata[15:8] : hi_addr;
        bus.lower_host_oe  = (cur.st == H_ADDR) || (cur.st == H_LATCH)
                           || (cur.st == H_DATA && cur.wr);
        bus.upper_host_oe  = bus.lower_host_oe;
        // Write control: strobe low, or direction low for write.
        if (write_style == WR_STROBE)
            bus.write_control_input = ~(cur.st == H_DATA && cur.wr);
        else
            bus.write_control_input = ~cur.wr || cur.st == H_IDLE;
        // Read control also acts as the data strobe of a direction-style write.
        bus.read_control_input   = ~(cur.st == H_DATA
                                   && (!cur.wr || write_style == WR_RW));
        bus.program_select_input = ~(cur.st == H_DATA && cur.code);
    end

endmodule : mcu_bus_host
`default_nettype wire

// [mcu_bus_host_port_checker.sv]
// Concurrent checks on the pins joining the host end and the bus port.
`timescale 1ns/1ps
`default_nettype none
module mcu_bus_host_port_checker
    import mcu_bus_pkg::*;
(
    // Clock, reset and wiring styles.
    input wire logic            clk,
    input wire logic            rst,
    input wire bus_mode_type    bus_mode,
    input wire write_style_type write_style,
    input wire read_style_type  read_style,
    // Drive signals of the shared ports.
    input wire logic            lower_host_oe,
    input wire logic [7:0]      lower_host_out,
    input wire logic            upper_host_oe,
    input wire logic            lower_dev_oe,
    input wire logic            upper_dev_oe,
    // Control pins.
    input wire logic            addr_strobe,
    input wire logic            write_control_input,
    input wire logic            read_control_input,
    input wire logic            reset_n
);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////
    // A strobe write holds its data on the lower port for the first three cycles of the data phase.
    sequence s_write_phase;
        (lower_host_oe && !write_control_input) [*3];
    endsequence

    // The device starts driving only after the read line has been low a while.
    sequence s_read_seen;
        !read_control_input && !$past(read_control_input, 3);
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    property p_reset_quiet;
        $fell(rst) |-> !lower_dev_oe && !upper_dev_oe;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("device drives the port right after reset");

    property p_reset_pin;
        $fell(rst) |-> ##[1:2] reset_n;
    endproperty
    a_reset_pin: assert property (p_reset_pin)
        else $error("reset pin not released after reset");

    property p_drive_needs_read;
        read_style == RD_STROBE && $rose(lower_dev_oe) |-> s_read_seen;
    endproperty
    a_drive_needs_read: assert property (p_drive_needs_read)
        else $error("device drove without an active read");

    property p_release;
        read_style == RD_STROBE && $rose(read_control_input) |-> ##[1:6] !lower_dev_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("device kept driving after the read ended");

    property p_no_contention;
        lower_dev_oe |-> !lower_host_oe;
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("both ends drive the lower port");

    property p_addr_at_strobe;
        $rose(addr_strobe) |-> lower_host_oe && upper_host_oe && $stable(lower_host_out);
    endproperty
    a_addr_at_strobe: assert property (p_addr_at_strobe)
        else $error("address not steady while the strobe rises");

    property p_write_phase;
        bus_mode == BUS_MUX && write_style == WR_STROBE && $fell(write_control_input)
            |-> s_write_phase;
    endproperty
    a_write_phase: assert property (p_write_phase)
        else $error("write data phase too short");

    property p_rw_exclusive;
        write_style == WR_STROBE |-> write_control_input || read_control_input;
    endproperty
    a_rw_exclusive: assert property (p_rw_exclusive)
        else $error("write and read strobes low together");

endmodule : mcu_bus_host_port_checker
`default_nettype wire

// [test_mcu_bus_host_port.sv]
// Self-checking testbench for the host end and the bus port joined by pins.
`timescale 1ns/1ps
`default_nettype none
module test_mcu_bus_host_port;
    import mcu_bus_pkg::*;

    logic clk, rst, req_valid, req_ready, req_write, req_code, rsp_valid;
    logic [15:0] req_addr, req_wdata, rsp_rdata, write_data, primary_rdata, secondary_rdata;
    bus_mode_type bus_mode;
    write_style_type write_style;
    read_style_type read_style;
    logic program_store_enable_n_used, swap_out, prim_data, sec_data, serial_prog, prim_busy, sec_busy;
    logic [7:0] prim_map, sec_map, page, drive_val, wr_val;
    logic [15:0] pld_addr;
    logic [23:0] mem_addr;
    logic pld_write, pld_read, pld_generic_in, write_strobe, busy_ok, drove, wrote;
    select_type selected;
    int fail_count, checks;

    ////////////////////////////////////////////////////////////////////////////
    mcu_bus_if mcu_bus_if_inst ();
    mcu_bus_host mcu_bus_host_inst (.clk(clk), .rst(rst), .bus_mode(bus_mode),
        .write_style(write_style), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_code(req_code), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .bus(mcu_bus_if_inst));
    mcu_bus_host_port mcu_bus_host_port_inst (.clk(clk), .rst(rst), .bus_mode(bus_mode),
        .write_style(write_style), .read_style(read_style), .program_store_enable_n_used(program_store_enable_n_used),
        .primary_seg_map(prim_map), .secondary_seg_map(sec_map),
        .secondary_swap_out(swap_out), .primary_as_data(prim_data),
        .secondary_as_data(sec_data), .serial_prog_active(serial_prog),
        .bus(mcu_bus_if_inst), .pld_addr(pld_addr), .mem_addr(mem_addr),
        .pld_write(pld_write), .pld_read(pld_read), .pld_generic_in(pld_generic_in),
        .write_strobe(write_strobe), .write_data(write_data), .selected(selected),
        .primary_busy_ok(busy_ok), .page(page), .primary_rdata(primary_rdata),
        .secondary_rdata(secondary_rdata), .primary_busy(prim_busy),
        .secondary_busy(sec_busy));
    mcu_bus_host_port_checker mcu_bus_host_port_checker_inst (.clk(clk), .rst(rst),
        .bus_mode(bus_mode), .write_style(write_style), .read_style(read_style),
        .lower_host_oe(mcu_bus_if_inst.lower_host_oe),
        .lower_host_out(mcu_bus_if_inst.lower_host_out),
        .upper_host_oe(mcu_bus_if_inst.upper_host_oe),
        .lower_dev_oe(mcu_bus_if_inst.lower_dev_oe),
        .upper_dev_oe(mcu_bus_if_inst.upper_dev_oe),
        .addr_strobe(mcu_bus_if_inst.addr_strobe),
        .write_control_input(mcu_bus_if_inst.write_control_input),
        .read_control_input(mcu_bus_if_inst.read_control_input),
        .reset_n(mcu_bus_if_inst.reset_n));

    // The memories answer with a pattern of the address they are given.
    assign primary_rdata   = mem_addr[15:0] ^ 16'ha5a5;
    assign secondary_rdata = mem_addr[15:0] ^ 16'h5a5a;

    // The clock runs at 40 MHz.
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Record whether the device drove read data or issued a write strobe.
    always @(posedge clk)
    begin
        if (mcu_bus_if_inst.lower_dev_oe === 1'b1)
        begin
            drove     <= 1'b1;
            drive_val <= mcu_bus_if_inst.lower_dev_out;
        end
        if (write_strobe === 1'b1)
        begin
            wrote  <= 1'b1;
            wr_val <= write_data[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (fail_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One host cycle, then time for the device's synchronisers to settle.
    task automatic op(input logic wr, input logic [15:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge clk);
        drove = 1'b0;
        wrote = 1'b0;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        while (req_ready !== 1'b1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        while ((wr ? req_ready : rsp_valid) !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 100)
            fail_count++;
        repeat (12) @(negedge clk);
    endtask : op

    // A read with the drive that the decode should allow.
    task automatic rd(input logic [15:0] a, input logic expd, input logic [15:0] val);
        op(1'b0, a, 16'h0000);
        chk(drove, expd);
        if (expd)
            chk(drive_val, val[7:0]);
        chk(rsp_rdata, expd ? val : 16'h0000);
    endtask : rd

    task automatic do_reset();
        @(negedge clk);
        rst = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
    endtask : do_reset

    // Watchdog cuts a hung run short.
    initial
    begin
        #(25 * 5000);
        fail_count++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst, req_valid, req_write, req_code, program_store_enable_n_used, swap_out} = 6'h20;
        {prim_data, sec_data, serial_prog, prim_busy, sec_busy, drove, wrote} = 7'h00;
        {req_addr, req_wdata, drive_val, wr_val} = 48'h0;
        {fail_count, checks} = 0;
        bus_mode = BUS_MUX;
        write_style = WR_STROBE;
        read_style = RD_STROBE;
        prim_map = 8'h0f;
        sec_map = 8'h30;
        do_reset();
        chk(mcu_bus_if_inst.lower_dev_oe, 1'b0);
        chk(page, 8'h00);
        for (int m = 0; m < 3; m++)
        begin
            bus_mode = bus_mode_type'(m);
            op(1'b1, 16'h1230 + 16'(m), 16'h00ab);
            // Burst hosts drop the low four address bits, so the device latches them as zero.
            chk(pld_addr, (m == 2) ? 16'h1230 : 16'h1230 + 16'(m));
        end
        bus_mode = BUS_MUX;
        for (int s = 0; s < 2; s++)
        begin
            write_style = write_style_type'(s);
            read_style = s ? RD_DSTROB : RD_STROBE;
            op(1'b1, 16'h0456, 16'h00c3);
            chk({wrote, wr_val}, 9'h1c3);
        end
        write_style = WR_STROBE;
        for (int s = 0; s < 2; s++)
        begin
            read_style = s ? RD_PROGRAM_STORE_ENABLE_N : RD_STROBE;
            rd(16'h0102, 1'b1, 16'h0102 ^ 16'ha5a5);
        end
        read_style = RD_STROBE;
        chk({pld_read, pld_write, pld_generic_in}, 3'h7);
        rd(16'h8010, 1'b1, 16'h8010 ^ 16'h5a5a);
        rd(16'he000, 1'b0, 16'h0000);
        prim_busy = 1'b1;
        chk(busy_ok, 1'b1);
        rd(16'h0102, 1'b0, 16'h0000);
        rd(16'h8010, 1'b1, 16'h8010 ^ 16'h5a5a);
        prim_busy = 1'b0;
        swap_out = 1'b1;
        rd(16'h8010, 1'b0, 16'h0000);
        swap_out = 1'b0;
        serial_prog = 1'b1;
        rd(16'h0102, 1'b0, 16'h0000);
        serial_prog = 1'b0;
        op(1'b1, 16'hffff, 16'h0007);
        chk(page, 8'h07);
        op(1'b0, 16'h0102, 16'h0000);
        chk(mem_addr, 24'h070102);
        chk(selected, SEL_PRIMARY);
        do_reset();
        chk(page, 8'h00);
        print_verdict();
    end

endmodule : test_mcu_bus_host_port
`default_nettype wire
